// ==== fas_pkg.sv ====
// fas_pkg: constants and types of the frame aligner test and supervision block
package fas_pkg;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CHAN = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_CNT = 8'h0c;
	localparam int C_T1 = 0;
	localparam int C_SIM = 1;
	localparam int C_CLR = 2;
	localparam int C_CLRP = 3;
	localparam int C_CRD = 4;
	localparam int C_CRC = 5;
	localparam int C_XAIS = 6;
	localparam int C_DAIS = 7;
	localparam int C_RTM = 8;
	localparam int C_TT0 = 9;
	localparam int C_TM = 10;
	localparam int C_EPY = 11;
	localparam int C_EPYS = 12;
	localparam int C_RPYS = 13;
	localparam int C_SLB = 14;
	localparam int C_LOOP = 15;
	localparam int CH_PAR_LSB = 0;
	localparam int CH_LOOP_LSB = 8;
	localparam int CH_IDLE_LSB = 16;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] CTRL_RD_MASK = 16'hfff3;
	localparam logic [7:0] IDLE_RST = 8'h54;
	localparam logic [4:0] PAR_CH_RST = 5'h00;
	localparam logic [4:0] LOOP_CH_RST = 5'h00;
	localparam logic [7:0] AIS_BYTE = 8'hff;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [4:0] FSDL_SLOT = 5'h00;
	localparam int NUM_SLOTS = 32;
	typedef enum logic [2:0] {
		STEP_IDLE = 3'b000,
		STEP_NOS = 3'b001,
		STEP_AIS = 3'b010,
		STEP_LOF = 3'b011,
		STEP_RAI = 3'b100,
		STEP_SLIP = 3'b101,
		STEP_PAR = 3'b110,
		STEP_CNT = 3'b111
	} fas_step_e;
endpackage

// ==== fas_top.sv ====
// fas_top: alarm simulation, speech memory parity, channel loop, transparency and test outputs
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fas_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic slot_strobe,
	input wire logic [4:0] slot_num,
	input wire logic frame_start,
	input wire logic [7:0] rx_line_byte,
	input wire logic rx_sync,
	input wire logic rx_fbit,
	input wire logic rx_fbit_is_dl,
	input wire logic [3:0] real_alarm_in,
	input wire logic rx_slip_evt,
	input wire logic tx_slip_evt,
	input wire logic frame_err_evt,
	input wire logic code_viol_evt,
	input wire logic crc_err_evt,
	input wire logic rai_request_in,
	input wire logic [7:0] system_tx_input,
	input wire logic [7:0] signaling_input,
	input wire logic [7:0] sig_bit_mask,
	input wire logic ext_tx_parity_in,
	input wire logic out_of_service,
	input wire logic tx_fbit_in,
	input wire logic enc_strobe,
	input wire logic enc_pos,
	input wire logic enc_neg,
	input wire logic enc_uni,
	output logic [7:0] system_rx_output,
	output logic rx_parity_out,
	output logic [7:0] tx_line_byte,
	output logic tx_fbit_out,
	output logic tx_framing_bypass,
	output logic [3:0] alarm_status,
	output logic remote_alarm_out,
	output logic doubleframe_parity_out,
	output logic line_out_pos,
	output logic line_out_neg,
	output logic line_out_unipolar,
	output logic test_line_out_pos,
	output logic test_line_out_neg
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [4:0] par_ch;
		logic [4:0] loop_ch;
		logic [7:0] idle;
		logic trig_d;
		logic clr_d;
		logic clrp_d;
		fas_pkg::fas_step_e step;
		logic [3:0] alarm;
		logic rai_out;
		logic rslip;
		logic xslip;
		logic rpe;
		logic xpe;
		logic gpe;
		logic [7:0] cnt_fe;
		logic [7:0] cnt_cv;
		logic [7:0] cnt_crc;
		logic [fas_pkg::NUM_SLOTS-1:0][8:0] rxmem;
		logic [fas_pkg::NUM_SLOTS-1:0][8:0] txmem;
		logic [7:0] rx_out;
		logic rxpar;
		logic [7:0] tx_out;
		logic fbit;
		logic df_acc;
		logic df_half;
		logic df_out;
		logic lpos;
		logic lneg;
		logic luni;
		logic ais_ph;
		logic xpar_s1;
		logic xpar_s2;
		logic oos_s1;
		logic oos_s2;
		logic a_wr;
		logic [7:0] a_addr;
	} fas_state_s;

	fas_state_s st_q;
	fas_state_s st_d;

	function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic en);
		sat_inc = (en && v != fas_pkg::CNT_MAX) ? v + 8'h01 : v;
	endfunction

	logic t1, trig, sim_act, step_rise, clr_ok, clr_fall, clrp_fall;
	logic [3:0] sim_al;
	logic sim_slip, sim_par, sim_cnt, rx_pass, fsdl, loop_hit, tx_par, rx_perr, tx_perr, ais_tx;
	logic [7:0] rx_in, tx_merge, tx_word, loop_data;
	logic [8:0] rx_rd, tx_rd;

	assign t1 = st_q.ctrl[fas_pkg::C_T1];
	assign trig = st_q.ctrl[fas_pkg::C_SIM];
	// e1 follows the bit level; t1 runs until the step counter is back at zero
	assign sim_act = t1 ? (st_q.step != fas_pkg::STEP_IDLE) : trig;
	assign step_rise = t1 & trig & ~st_q.trig_d;
	assign clr_ok = ~t1 | (st_q.step == fas_pkg::STEP_IDLE);
	assign clr_fall = st_q.clr_d & ~st_q.ctrl[fas_pkg::C_CLR] & clr_ok;
	assign clrp_fall = (st_q.clrp_d & ~st_q.ctrl[fas_pkg::C_CLRP] & clr_ok) | (t1 & clr_fall);
	assign sim_al = t1 ? {st_q.step == fas_pkg::STEP_RAI, st_q.step == fas_pkg::STEP_LOF,
		st_q.step == fas_pkg::STEP_AIS, st_q.step == fas_pkg::STEP_NOS} : {4{trig}};
	assign sim_slip = sim_act & (t1 ? st_q.step == fas_pkg::STEP_SLIP : frame_start);
	assign sim_par = sim_act & (t1 ? st_q.step == fas_pkg::STEP_PAR : frame_start);
	assign sim_cnt = sim_act & frame_start & (~t1 | st_q.step == fas_pkg::STEP_CNT);
	assign rx_pass = t1 | rx_sync | (st_q.ctrl[fas_pkg::C_DAIS] & st_q.ctrl[fas_pkg::C_RTM]);
	assign fsdl = t1 & st_q.ctrl[fas_pkg::C_TM] & (slot_num == fas_pkg::FSDL_SLOT);
	// dl flag sits in bit 1 (msb), the f-bit itself in bit 8 (lsb)
	assign rx_in = fsdl ? {rx_fbit_is_dl, 6'h00, rx_fbit} : (rx_pass ? rx_line_byte : fas_pkg::AIS_BYTE);
	assign rx_rd = st_q.rxmem[slot_num];
	assign tx_merge = (system_tx_input & ~sig_bit_mask) | (signaling_input & sig_bit_mask);
	assign tx_word = t1 ? tx_merge : system_tx_input;
	assign loop_data = (t1 & ~st_q.ctrl[fas_pkg::C_SLB]) ? tx_merge : system_tx_input;
	assign loop_hit = st_q.ctrl[fas_pkg::C_LOOP] & (slot_num == st_q.loop_ch);
	// pin is synchronised, so it must settle two clocks before the strobe
	assign tx_par = st_q.ctrl[fas_pkg::C_EPY] ? (st_q.xpar_s2 ^ st_q.ctrl[fas_pkg::C_EPYS]) : ^tx_word;
	assign tx_rd = t1 ? st_q.txmem[slot_num] : {tx_par, tx_word};
	assign rx_perr = slot_strobe & (^rx_rd);
	assign tx_perr = slot_strobe & (^tx_rd);
	assign ais_tx = st_q.ctrl[fas_pkg::C_XAIS] | st_q.oos_s2;

	always_comb begin
		st_d = st_q;
		st_d.trig_d = trig;
		st_d.clr_d = st_q.ctrl[fas_pkg::C_CLR];
		st_d.clrp_d = st_q.ctrl[fas_pkg::C_CLRP];
		st_d.xpar_s1 = ext_tx_parity_in;
		st_d.xpar_s2 = st_q.xpar_s1;
		st_d.oos_s1 = out_of_service;
		st_d.oos_s2 = st_q.oos_s1;
		if (!t1) begin
			st_d.step = fas_pkg::STEP_IDLE;
		end else if (step_rise) begin
			st_d.step = fas_pkg::fas_step_e'(st_q.step + 3'h1);
		end
		st_d.alarm = sim_act ? sim_al : real_alarm_in;
		st_d.rai_out = ~sim_act & rai_request_in;
		if (clr_fall) begin
			st_d.rslip = 1'b0;
			st_d.xslip = 1'b0;
			st_d.cnt_fe = 8'h00;
			st_d.cnt_cv = 8'h00;
			st_d.cnt_crc = 8'h00;
		end
		if (clrp_fall) begin
			st_d.rpe = 1'b0;
			st_d.xpe = 1'b0;
			st_d.gpe = 1'b0;
		end
		// sets come after clears so a same-cycle event is kept
		if (sim_slip | (~sim_act & rx_slip_evt)) begin
			st_d.rslip = 1'b1;
		end
		if (sim_slip | (~sim_act & tx_slip_evt)) begin
			st_d.xslip = 1'b1;
		end
		if (sim_par | (~sim_act & rx_perr & slot_num == st_q.par_ch)) begin
			st_d.rpe = 1'b1;
		end
		if (sim_par | (~sim_act & tx_perr & slot_num == st_q.par_ch)) begin
			st_d.xpe = 1'b1;
		end
		if (sim_par | (~sim_act & (rx_perr | tx_perr))) begin
			st_d.gpe = 1'b1;
		end
		st_d.cnt_fe = sat_inc(st_d.cnt_fe, sim_cnt | (~sim_act & frame_err_evt));
		st_d.cnt_cv = sat_inc(st_d.cnt_cv, sim_cnt | (~sim_act & code_viol_evt));
		st_d.cnt_crc = sat_inc(st_d.cnt_crc,
			(sim_cnt & st_q.ctrl[fas_pkg::C_CRC]) | (~sim_act & crc_err_evt));
		st_d.a_wr = hsel & hready & htrans[1] & hwrite;
		st_d.a_addr = (hsel & hready & htrans[1]) ? haddr[7:0] : st_q.a_addr;
		if (st_q.a_wr) begin
			case (st_q.a_addr)
				fas_pkg::A_CTRL: begin
					st_d.ctrl = hwdata[15:0];
				end
				fas_pkg::A_CHAN: begin
					st_d.par_ch = hwdata[fas_pkg::CH_PAR_LSB +: 5];
					st_d.loop_ch = hwdata[fas_pkg::CH_LOOP_LSB +: 5];
					st_d.idle = hwdata[fas_pkg::CH_IDLE_LSB +: 8];
				end
				default: begin
				end
			endcase
		end
		if (slot_strobe) begin
			st_d.rxmem[slot_num] = {^rx_in, rx_in};
			if (t1) begin
				st_d.txmem[slot_num] = {tx_par, tx_word};
			end
			st_d.rx_out = loop_hit ? loop_data : rx_rd[7:0];
			st_d.rxpar = (loop_hit ? ^loop_data : rx_rd[8]) ^ st_q.ctrl[fas_pkg::C_RPYS];
			st_d.tx_out = loop_hit ? st_q.idle : tx_rd[7:0];
			st_d.df_acc = ((frame_start & st_q.df_half) ? 1'b0 : st_q.df_acc) ^ (^rx_in);
			if (frame_start) begin
				st_d.df_half = ~st_q.df_half;
				if (st_q.df_half) begin
					st_d.df_out = ~t1 & st_q.df_acc;
				end
			end
		end
		if (t1 & st_q.ctrl[fas_pkg::C_TM]) begin
			st_d.fbit = (slot_strobe & fsdl) ? system_tx_input[0] : st_q.fbit;
		end else begin
			st_d.fbit = tx_fbit_in;
		end
		if (enc_strobe) begin
			if (ais_tx) begin
				// all-ones as alternating marks keeps the bipolar code legal
				st_d.lpos = st_q.ais_ph;
				st_d.lneg = ~st_q.ais_ph;
				st_d.luni = 1'b1;
				st_d.ais_ph = ~st_q.ais_ph;
			end else begin
				st_d.lpos = enc_pos;
				st_d.lneg = enc_neg;
				st_d.luni = enc_uni;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.ctrl <= fas_pkg::CTRL_RST;
			st_q.par_ch <= fas_pkg::PAR_CH_RST;
			st_q.loop_ch <= fas_pkg::LOOP_CH_RST;
			st_q.idle <= fas_pkg::IDLE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		case (st_q.a_addr)
			fas_pkg::A_CTRL: begin
				hrdata = st_q.ctrl[fas_pkg::C_CRD] ? {16'h0000, st_q.ctrl & fas_pkg::CTRL_RD_MASK} : 32'h0000_0000;
			end
			fas_pkg::A_CHAN: begin
				hrdata = st_q.ctrl[fas_pkg::C_CRD] ?
					{8'h00, st_q.idle, 3'h0, st_q.loop_ch, 3'h0, st_q.par_ch} : 32'h0000_0000;
			end
			fas_pkg::A_STAT: begin
				hrdata = {20'h0_0000, st_q.step, st_q.gpe, st_q.xpe, st_q.rpe, st_q.xslip, st_q.rslip, st_q.alarm};
			end
			fas_pkg::A_CNT: begin
				hrdata = {8'h00, st_q.cnt_crc, st_q.cnt_cv, st_q.cnt_fe};
			end
			default: begin
				hrdata = 32'h0000_0000;
			end
		endcase
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign system_rx_output = st_q.rx_out;
	assign rx_parity_out = st_q.rxpar;
	assign tx_line_byte = st_q.tx_out;
	assign tx_fbit_out = st_q.fbit;
	assign tx_framing_bypass = t1 ? st_q.ctrl[fas_pkg::C_TM] : st_q.ctrl[fas_pkg::C_TT0];
	assign alarm_status = st_q.alarm;
	assign remote_alarm_out = st_q.rai_out;
	assign doubleframe_parity_out = st_q.df_out;
	assign line_out_pos = st_q.lpos;
	assign line_out_neg = st_q.lneg;
	assign line_out_unipolar = st_q.luni;
	assign test_line_out_pos = st_q.lpos;
	assign test_line_out_neg = st_q.lneg;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_sim_hides;
		sim_act && rai_request_in |=> !remote_alarm_out && alarm_status == $past(sim_al);
	endproperty
	a_sim_hides: assert property (p_sim_hides) else $error("real alarm leaked during simulation");

	property p_no_crc_sim;
		sim_cnt && !st_q.ctrl[fas_pkg::C_CRC] && !crc_err_evt && !clr_fall |=> $stable(st_q.cnt_crc);
	endproperty
	a_no_crc_sim: assert property (p_no_crc_sim) else $error("crc error simulated without crc framing");

	property p_e1_count;
		!t1 && trig && frame_start && st_q.cnt_fe < 8'hfe && !clr_fall |=> st_q.cnt_fe == $past(st_q.cnt_fe) + 8'h01;
	endproperty
	a_e1_count: assert property (p_e1_count) else $error("simulated frame error not counted");

	property p_e1_sticky;
		!t1 && st_q.rslip && !clr_fall |=> st_q.rslip;
	endproperty
	a_e1_sticky: assert property (p_e1_sticky) else $error("slip indication lost without clear");

	property p_t1_step;
		t1 && trig && !st_q.trig_d && !st_q.a_wr |=> st_q.step == fas_pkg::fas_step_e'($past(st_q.step) + 3'h1);
	endproperty
	a_t1_step: assert property (p_t1_step) else $error("step counter did not advance");

	property p_t1_hold;
		t1 && st_q.step != fas_pkg::STEP_IDLE && st_q.cnt_fe != 8'h00 ##1 t1 |-> st_q.cnt_fe != 8'h00;
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("counter cleared at wrong step");

	property p_rx_chan_par;
		rx_perr && slot_num == st_q.par_ch && !sim_act && !clrp_fall |=> st_q.rpe && st_q.gpe;
	endproperty
	a_rx_chan_par: assert property (p_rx_chan_par) else $error("rx parity error not flagged");

	property p_loop;
		slot_strobe && loop_hit |=> tx_line_byte == $past(st_q.idle) && system_rx_output == $past(loop_data);
	endproperty
	a_loop: assert property (p_loop) else $error("loop channel data or idle code wrong");

	property p_dfpar;
		slot_strobe && frame_start && st_q.df_half && !t1 |=> doubleframe_parity_out == $past(st_q.df_acc);
	endproperty
	a_dfpar: assert property (p_dfpar) else $error("doubleframe parity wrong");

	property p_rx_ais;
		slot_strobe && !t1 && !rx_sync && !(st_q.ctrl[fas_pkg::C_DAIS] && st_q.ctrl[fas_pkg::C_RTM])
			|=> st_q.rxmem[$past(slot_num)][7:0] == 8'hff;
	endproperty
	a_rx_ais: assert property (p_rx_ais) else $error("unsynced data passed");

	property p_t1_fbit;
		slot_strobe && fsdl ##1 t1 && st_q.ctrl[fas_pkg::C_TM] |-> tx_fbit_out == $past(system_tx_input[0]);
	endproperty
	a_t1_fbit: assert property (p_t1_fbit) else $error("f-bit not taken from fs/dl slot");

	property p_cov_t1_wrap;
		t1 && st_q.step == fas_pkg::STEP_CNT && step_rise;
	endproperty
	c_t1_wrap: cover property (p_cov_t1_wrap);

	property p_cov_loop;
		slot_strobe && loop_hit;
	endproperty
	c_loop: cover property (p_cov_loop);

	property p_cov_e1_sim;
		!t1 && trig && frame_start ##[1:300] clr_fall;
	endproperty
	c_e1_sim: cover property (p_cov_e1_sim);
endmodule
`default_nettype wire

// ==== fas_highway_model.sv ====
// fas_highway_model: system highway partner, one time-slot every other clock
`timescale 1ns/1ps
`default_nettype none
module fas_highway_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [7:0] rx_b,
	input wire logic [7:0] tx_b,
	input wire logic [4:0] quiet_slot,
	input wire logic [7:0] quiet_byte,
	output logic slot_strobe,
	output logic [4:0] slot_num,
	output logic frame_start,
	output logic [7:0] rx_line_byte,
	output logic [7:0] system_tx_input
);
	logic [4:0] cnt;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{cnt, slot_strobe, slot_num, frame_start, rx_line_byte, system_tx_input} <= '0;
		end else if (run && !slot_strobe) begin
			slot_strobe <= 1'b1;
			slot_num <= cnt;
			frame_start <= (cnt == 5'h00);
			rx_line_byte <= rx_b;
			// looped slot gets a static pattern so the bench's one-frame receive memory still matches the direct loop
			system_tx_input <= (cnt == quiet_slot) ? quiet_byte : tx_b;
			cnt <= cnt + 5'h01;
		end else begin
			slot_strobe <= 1'b0;
			frame_start <= 1'b0;
			// bytes are not held between slots
			rx_line_byte <= ~rx_line_byte;
			system_tx_input <= ~system_tx_input;
		end
	end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// testbench: self-checking bench for the test and supervision block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, slot_strobe, frame_start, rx_sync, rx_fbit, rx_fbit_is_dl;
	logic rx_slip_evt, tx_slip_evt, frame_err_evt, code_viol_evt, crc_err_evt, rai_request_in, ext_tx_parity_in;
	logic out_of_service, tx_fbit_in, enc_strobe, enc_pos, enc_neg, enc_uni, rx_parity_out, tx_fbit_out;
	logic tx_framing_bypass, remote_alarm_out, doubleframe_parity_out, line_out_pos, line_out_neg;
	logic line_out_unipolar, test_line_out_pos, test_line_out_neg, run, ev_en;
	logic [31:0] haddr, hwdata, hrdata, r, cnt_sim;
	logic [1:0] htrans;
	logic [2:0] hsize, epl;
	logic [4:0] slot_num, ps;
	logic [3:0] real_alarm_in, alarm_status;
	logic [7:0] rx_line_byte, system_tx_input, signaling_input, system_rx_output, tx_line_byte, rx_b, tx_b;
	logic [7:0] e_rx, e_tx, idle;
	logic [7:0] mem [32];
	logic [15:0] lfsr;
	int mismatches, check_count, cycles;
	bit chk, pend, loop_on, rsense, dais_rtm, lchk, ais, lp;

	fas_top fas_top_i (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .slot_strobe, .slot_num, .frame_start, .rx_line_byte, .rx_sync, .rx_fbit,
		.rx_fbit_is_dl, .real_alarm_in, .rx_slip_evt, .tx_slip_evt, .frame_err_evt, .code_viol_evt, .crc_err_evt,
		.rai_request_in, .system_tx_input, .signaling_input, .sig_bit_mask(8'h00), .ext_tx_parity_in,
		.out_of_service, .tx_fbit_in, .enc_strobe, .enc_pos, .enc_neg, .enc_uni, .system_rx_output, .rx_parity_out,
		.tx_line_byte, .tx_fbit_out, .tx_framing_bypass, .alarm_status, .remote_alarm_out, .doubleframe_parity_out,
		.line_out_pos, .line_out_neg, .line_out_unipolar, .test_line_out_pos, .test_line_out_neg);
	fas_highway_model fas_highway_model_i (.clk, .rst_n, .run, .rx_b, .tx_b, .quiet_slot(5'h05),
		.quiet_byte(8'h3c), .slot_strobe, .slot_num, .frame_start, .rx_line_byte, .system_tx_input);

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		cmp(r, exp);
	endtask

	task automatic frames(input int n);
		repeat (n * 64) @(posedge clk);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		lfsr <= nxt(lfsr);
		enc_strobe <= lfsr[0] & ~enc_strobe;
		{enc_pos, enc_neg, enc_uni} <= lfsr[3:1];
		rx_b <= lfsr[7:0];
		tx_b <= lfsr[15:8];
		signaling_input <= lfsr[11:4];
		{rx_fbit, rx_fbit_is_dl, tx_fbit_in, ext_tx_parity_in} <= lfsr[9:6];
		// real alarms and events only while the bench expects them hidden
		real_alarm_in <= ev_en ? lfsr[13:10] : 4'h0;
		{rx_slip_evt, tx_slip_evt, frame_err_evt, code_viol_evt, crc_err_evt} <= ev_en ? lfsr[15:11] : 5'h00;
		cycles++;
		if (cycles > 20000) begin
			mismatches++;
			results();
		end
	end

	// reference model: one-frame receive memory, transmit bypass, channel loop
	always @(negedge clk) begin
		if (rst_n) begin
			cmp({30'h0, test_line_out_pos, test_line_out_neg}, {30'h0, line_out_pos, line_out_neg});
			if (lp && ais) cmp(32'(line_out_pos ^ line_out_neg), 32'h0000_0001);
			else if (lp) cmp({29'h0, line_out_pos, line_out_neg, line_out_unipolar}, {29'h0, epl});
			lp = lchk && enc_strobe;
			epl = {enc_pos, enc_neg, enc_uni};
			if (pend) begin
				cmp(32'(system_rx_output), 32'(e_rx));
				cmp(32'(rx_parity_out), 32'(^e_rx ^ rsense));
				if (ps != 5'h00) cmp(32'(tx_line_byte), 32'(e_tx));
				pend = 1'b0;
			end
			if (slot_strobe) begin
				ps = slot_num;
				e_rx = mem[ps];
				e_tx = (loop_on && ps == 5'h05) ? idle : system_tx_input;
				if (loop_on && ps == 5'h05) mem[ps] = system_tx_input;
				else mem[ps] = (rx_sync || dais_rtm) ? rx_line_byte : 8'hff;
				pend = chk;
			end
		end
	end

	initial begin
		{hsel, hwrite, run, ev_en, rx_sync, rai_request_in, out_of_service, enc_strobe} = '0;
		{enc_pos, enc_neg, enc_uni, rx_fbit, rx_fbit_is_dl, tx_fbit_in, ext_tx_parity_in} = '0;
		{rx_slip_evt, tx_slip_evt, frame_err_evt, code_viol_evt, crc_err_evt, real_alarm_in} = '0;
		{haddr, hwdata, htrans, rx_b, tx_b, signaling_input} = '0;
		hsize = 3'b010;
		lfsr = 16'h77c6;
		idle = 8'h54;
		foreach (mem[i]) mem[i] = 8'h00;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		lchk = 1'b1;
		rdc(fas_pkg::A_CTRL, 32'h0000_0000);
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_001c);
		rdc(fas_pkg::A_CTRL, 32'h0000_0010);
		rdc(fas_pkg::A_CHAN, 32'h0054_0000);
		rdc(8'h10, 32'h0000_0000);
		cmp(32'(hresp), 32'h0000_0000);
		run <= 1'b1;
		rx_sync <= 1'b1;
		frames(1);
		chk = 1'b1;
		frames(2);
		// each reconfiguration gets one unchecked frame to settle
		chk = 1'b0;
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_2010);
		rsense = 1'b1;
		frames(1);
		chk = 1'b1;
		frames(1);
		chk = 1'b0;
		rx_sync <= 1'b0;
		frames(1);
		chk = 1'b1;
		frames(1);
		chk = 1'b0;
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_2190);
		dais_rtm = 1'b1;
		frames(1);
		chk = 1'b1;
		frames(1);
		chk = 1'b0;
		rx_sync <= 1'b1;
		ahb(1'b1, fas_pkg::A_CHAN, 32'h00a5_0500);
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_a190);
		idle = 8'ha5;
		loop_on = 1'b1;
		frames(1);
		chk = 1'b1;
		frames(2);
		chk = 1'b0;
		rdc(fas_pkg::A_CHAN, 32'h00a5_0500);
		rai_request_in <= 1'b1;
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_0012);
		// events only once the trigger stands, else they count as real ones
		ev_en = 1'b1;
		loop_on = 1'b0;
		rsense = 1'b0;
		frames(1);
		chk = 1'b1;
		frames(2);
		chk = 1'b0;
		cmp(32'(alarm_status), 32'h0000_000f);
		cmp(32'(remote_alarm_out), 32'h0000_0000);
		rdc(fas_pkg::A_STAT, 32'h0000_01ff);
		ev_en = 1'b0;
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_0010);
		// counters run until the trigger drops, so the snapshot follows it
		ahb(1'b0, fas_pkg::A_CNT, 32'h0000_0000);
		cnt_sim = r;
		cmp(32'(r[23:16]), 32'h0000_0000);
		cmp(32'(r[7:0] == r[15:8] && r[7:0] != 8'h00), 32'h0000_0001);
		frames(1);
		cmp(32'(alarm_status), 32'h0000_0000);
		cmp(32'(remote_alarm_out), 32'h0000_0001);
		rdc(fas_pkg::A_STAT, 32'h0000_01f0);
		rdc(fas_pkg::A_CNT, cnt_sim);
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_001c);
		ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_0010);
		rdc(fas_pkg::A_STAT, 32'h0000_0000);
		rdc(fas_pkg::A_CNT, 32'h0000_0000);
		for (int k = 1; k <= 8; k++) begin
			ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_0013);
			ahb(1'b0, fas_pkg::A_STAT, 32'h0000_0000);
			cmp(32'(r[11:9]), 32'(k % 8));
			cmp(32'(alarm_status), (k < 5) ? (32'h0000_0001 << (k - 1)) : 32'h0000_0000);
			ahb(1'b1, fas_pkg::A_CTRL, 32'h0000_0011);
			ahb(1'b0, fas_pkg::A_STAT, 32'h0000_0000);
			cmp(32'(r[11:9]), 32'(k % 8));
		end
		// pin passes two flops, so line checks pause meanwhile
		lchk = 1'b0;
		out_of_service <= 1'b1;
		repeat (6) @(posedge clk);
		ais = 1'b1;
		lchk = 1'b1;
		repeat (200) @(posedge clk);
		results();
	end
endmodule
`default_nettype wire
